// ==== design/plh_lock_holdover.sv ====
// Functional notes
// - Lock declared after selected count of consecutive cycles below lock window.
// - Lock held until one cycle exceeds unlock window, then dropped at once.
// - Unlock window always wider than lock window, giving hysteresis.
// - Windows depend on window select and backlash width only.
// - Counter code zero means five qualifying cycles.
// - Window select zero picks the high range window.
// - Lock detector runs only while its disable bit is zero.
// - Lock flag selectable onto lock, status and monitor pins.
// - Lock pin comparator routable to monitor or status pin.
// - Lock pin code 0x04 selects charged current-source lock mode.
// - Comparator disabled means holdover sees the lock pin as high.
// - Global holdover enable gates both holdover modes.
// - External holdover bit: zero automatic, one sync-pin manual.
// - Manual: sync falling edge tri-states the charge pump immediately.
// - Manual exit after sync high on next reference edge only.
// - Leaving tri-state resets feedback B counter on that same edge.
// - Channels without ignore-sync turn off while sync is low.
// - Automatic: sensed lock pin low enters tri-state.
// - After automatic exit, no re-entry until lock pin goes high.
// - Holdover follows selected reference; exits on its next edge.
// - Switchover enable, preferred reference and buffer enables pick the reference.
// - Gated outputs enable only while charged qualifier is high.
`default_nettype none
module plh_lock_holdover (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Reference edges at the phase detector
  input wire logic first_reference_edge_i,
  input wire logic second_reference_edge_i,
  input wire logic [7:0] edge_diff_i,
  // Lock detect configuration
  input wire logic [1:0] lock_count_sel_i,
  input wire logic lock_window_sel_i,
  input wire logic [1:0] backlash_width_i,
  input wire logic dld_disable_i,
  input wire logic [15:0] qual_term_cnt_i,
  // Pin control
  input wire logic [5:0] lock_pin_ctrl_i,
  input wire logic [5:0] status_pin_ctrl_i,
  input wire logic [4:0] monitor_pin_ctrl_i,
  input wire logic lock_cmp_en_i,
  // Holdover control
  input wire logic holdover_en_i,
  input wire logic ext_holdover_i,
  input wire logic sync_n_i,
  // Reference selection
  input wire logic auto_switch_en_i,
  input wire logic prefer_second_i,
  input wire logic [1:0] ref_buf_en_i,
  // Channel and output gating
  input wire logic [3:0] ignore_sync_i,
  input wire logic [15:0] out_req_en_i,
  input wire logic [15:0] out_gate_en_i,
  // Lock status
  output logic edge_window_lock_flag_o,
  output logic charged_lock_qualifier_o,
  output logic lock_pin_o,
  output logic status_pin_o,
  output logic reference_monitor_pin_o,
  // Holdover status
  output logic cp_hiz_o,
  output logic b_cnt_reset_o,
  output logic ref_sel_o,
  // Distribution
  output logic [3:0] dist_off_o,
  output logic [15:0] out_en_o
);
  typedef struct packed {
    plh_pkg::plh_ho_state_t ho;
    logic sync_prev;
    logic [7:0] lock_cnt;
    logic edge_window_lock_flag;
    logic ref_sel;
    logic cp_hiz;
    logic b_rst;
    logic lock_pin;
    logic status_pin;
    logic mon_pin;
    logic [3:0] dist_off;
    logic [15:0] out_en;
  } plh_st_t;

  plh_st_t st_r;
  plh_st_t st_nxt;
  logic charged_lock_qualifier;

  // Required consecutive count for a counter code
  function automatic logic [7:0] lock_need(input logic [1:0] sel);
    logic [7:0] n;
    unique case (sel)
      plh_pkg::LCNT_SEL_5: n = plh_pkg::LCNT_5;
      plh_pkg::LCNT_SEL_B: n = plh_pkg::LCNT_B;
      plh_pkg::LCNT_SEL_C: n = plh_pkg::LCNT_C;
      default: n = plh_pkg::LCNT_D;
    endcase
    return n;
  endfunction

  // Lock window from range and backlash width
  function automatic logic [7:0] lock_thr(input logic win, input logic [1:0] abl);
    logic [7:0] t;
    if (win == plh_pkg::WIN_HIGH)
    begin
      unique case (abl)
        2'h0: t = plh_pkg::LTHR_HI_0;
        2'h1: t = plh_pkg::LTHR_HI_1;
        2'h2: t = plh_pkg::LTHR_HI_2;
        default: t = plh_pkg::LTHR_HI_3;
      endcase
    end
    else
    begin
      unique case (abl)
        2'h0: t = plh_pkg::LTHR_LO_0;
        2'h1: t = plh_pkg::LTHR_LO_1;
        2'h2: t = plh_pkg::LTHR_LO_2;
        default: t = plh_pkg::LTHR_LO_3;
      endcase
    end
    return t;
  endfunction

  plh_qual u_qual (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .lock_flag_i(st_r.edge_window_lock_flag),
    .term_cnt_i(qual_term_cnt_i),
    .charged_lock_qualifier_o(charged_lock_qualifier)
  );

  logic ref_sel;
  logic ref_edge;
  logic [7:0] lthr;
  logic [7:0] uthr;
  logic [7:0] need;
  logic sensed;
  logic sync_fall;
  logic leave;
  logic lp;

  always_comb
  begin
    st_nxt = st_r;
    // Preferred reference, swapped only when automatic switchover finds it disabled
    ref_sel = prefer_second_i;
    if (auto_switch_en_i && !ref_buf_en_i[prefer_second_i])
      ref_sel = !prefer_second_i;
    // Only the selected, enabled reference counts as an edge
    if (ref_sel)
      ref_edge = second_reference_edge_i && ref_buf_en_i[1];
    else
      ref_edge = first_reference_edge_i && ref_buf_en_i[0];
    st_nxt.ref_sel = ref_sel;

    // Window decode
    lthr = lock_thr(lock_window_sel_i, backlash_width_i);
    // Margin keeps unlock strictly wider; saturate at top
    if (lthr > (8'hFF - plh_pkg::UNLOCK_MARGIN))
      uthr = 8'hFF;
    else
      uthr = lthr + plh_pkg::UNLOCK_MARGIN;
    need = lock_need(lock_count_sel_i);

    // Digital lock detector, evaluated once per reference cycle
    if (dld_disable_i)
    begin
      st_nxt.edge_window_lock_flag = 1'b0;
      st_nxt.lock_cnt = plh_pkg::CNT_RST;
    end
    else if (ref_edge)
    begin
      if (st_r.edge_window_lock_flag)
      begin
        // One cycle past unlock window drops lock
        if (edge_diff_i > uthr)
        begin
          st_nxt.edge_window_lock_flag = 1'b0;
          st_nxt.lock_cnt = plh_pkg::CNT_RST;
        end
      end
      else if (edge_diff_i < lthr)
      begin
        if (st_r.lock_cnt + 8'h01 >= need)
        begin
          st_nxt.edge_window_lock_flag = 1'b1;
          st_nxt.lock_cnt = plh_pkg::CNT_RST;
        end
        else
        begin
          st_nxt.lock_cnt = st_r.lock_cnt + 8'h01;
        end
      end
      else
      begin
        // Run broken: start over
        st_nxt.lock_cnt = plh_pkg::CNT_RST;
      end
    end

    // Lock pin source
    unique case (lock_pin_ctrl_i)
      plh_pkg::LPIN_DLD: lp = st_r.edge_window_lock_flag;
      plh_pkg::LPIN_HIGH: lp = 1'b1;
      plh_pkg::LPIN_CSRC: lp = charged_lock_qualifier;
      default: lp = 1'b0;
    endcase
    st_nxt.lock_pin = lp;
    // Comparator off reads as high
    sensed = lock_cmp_en_i ? st_r.lock_pin : 1'b1;

    // Status pin source
    unique case (status_pin_ctrl_i)
      plh_pkg::STAT_DLD: st_nxt.status_pin = st_r.edge_window_lock_flag;
      plh_pkg::STAT_LDCMP: st_nxt.status_pin = lock_cmp_en_i && st_r.lock_pin;
      plh_pkg::STAT_HOLD: st_nxt.status_pin = st_r.cp_hiz;
      default: st_nxt.status_pin = 1'b0;
    endcase

    // Monitor pin source
    unique case (monitor_pin_ctrl_i)
      plh_pkg::RMON_DLD: st_nxt.mon_pin = st_r.edge_window_lock_flag;
      plh_pkg::RMON_LDCMP: st_nxt.mon_pin = lock_cmp_en_i && st_r.lock_pin;
      default: st_nxt.mon_pin = 1'b0;
    endcase

    // Holdover
    st_nxt.sync_prev = sync_n_i;
    sync_fall = st_r.sync_prev && !sync_n_i;
    leave = 1'b0;
    if (!holdover_en_i)
    begin
      st_nxt.ho = plh_pkg::HO_RUN;
    end
    else
    begin
      unique case (st_r.ho)
        plh_pkg::HO_RUN:
        begin
          if (ext_holdover_i)
          begin
            // Edge, not level, starts manual holdover
            if (sync_fall)
              st_nxt.ho = plh_pkg::HO_HOLD;
          end
          else if (!sensed)
          begin
            st_nxt.ho = plh_pkg::HO_HOLD;
          end
        end
        plh_pkg::HO_HOLD:
        begin
          // Without reference edges the pump stays tri-stated
          if (ref_edge && (!ext_holdover_i || sync_n_i))
          begin
            leave = 1'b1;
            st_nxt.ho = ext_holdover_i ? plh_pkg::HO_RUN : plh_pkg::HO_REARM;
          end
        end
        plh_pkg::HO_REARM:
        begin
          // Stale low lock pin must not retrigger at once
          if (ext_holdover_i)
          begin
            // A sync edge still counts after a mode change
            st_nxt.ho = sync_fall ? plh_pkg::HO_HOLD : plh_pkg::HO_RUN;
          end
          else if (sensed)
          begin
            st_nxt.ho = plh_pkg::HO_RUN;
          end
        end
        default: st_nxt.ho = plh_pkg::HO_RUN;
      endcase
    end
    st_nxt.cp_hiz = holdover_en_i && (st_nxt.ho == plh_pkg::HO_HOLD);
    // B counter reset pulses with the exit edge; prescaler untouched
    st_nxt.b_rst = leave;

    // Channel outputs off while sync low unless told to ignore
    st_nxt.dist_off = ~ignore_sync_i & {plh_pkg::NUM_CH{~sync_n_i}};
  end

  // Per-output gating on the charged qualifier
  genvar gi;
  logic [15:0] oen;
  generate
    for (gi = 0; gi < plh_pkg::NUM_OUT; gi++)
    begin : g_out
      assign oen[gi] = out_req_en_i[gi] && (!out_gate_en_i[gi] || charged_lock_qualifier);
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.ho <= plh_pkg::HO_RUN;
      st_r.sync_prev <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      st_r.out_en <= oen;
    end
  end

  assign edge_window_lock_flag_o = st_r.edge_window_lock_flag;
  assign charged_lock_qualifier_o = charged_lock_qualifier;
  assign lock_pin_o = st_r.lock_pin;
  assign status_pin_o = st_r.status_pin;
  assign reference_monitor_pin_o = st_r.mon_pin;
  assign cp_hiz_o = st_r.cp_hiz;
  assign b_cnt_reset_o = st_r.b_rst;
  assign ref_sel_o = st_r.ref_sel;
  assign dist_off_o = st_r.dist_off;
  assign out_en_o = st_r.out_en;
endmodule
`default_nettype wire

// ==== design/plh_pkg.sv ====
`default_nettype none
package plh_pkg;
  // Lock counter select codes and their cycle counts
  localparam logic [1:0] LCNT_SEL_5 = 2'h0;
  localparam logic [1:0] LCNT_SEL_B = 2'h1;
  localparam logic [1:0] LCNT_SEL_C = 2'h2;
  localparam logic [7:0] LCNT_5 = 8'h05;
  localparam logic [7:0] LCNT_B = 8'h10;
  localparam logic [7:0] LCNT_C = 8'h40;
  localparam logic [7:0] LCNT_D = 8'hFF;
  // Window select: zero is the high range
  localparam logic WIN_HIGH = 1'h0;
  // Lock thresholds in edge-difference units, per backlash width
  localparam logic [7:0] LTHR_HI_0 = 8'h20;
  localparam logic [7:0] LTHR_HI_1 = 8'h28;
  localparam logic [7:0] LTHR_HI_2 = 8'h30;
  localparam logic [7:0] LTHR_HI_3 = 8'h38;
  localparam logic [7:0] LTHR_LO_0 = 8'h08;
  localparam logic [7:0] LTHR_LO_1 = 8'h0C;
  localparam logic [7:0] LTHR_LO_2 = 8'h10;
  localparam logic [7:0] LTHR_LO_3 = 8'h14;
  // Unlock window is lock window plus this margin
  localparam logic [7:0] UNLOCK_MARGIN = 8'h10;
  // Lock pin control codes
  localparam logic [5:0] LPIN_LOW = 6'h00;
  localparam logic [5:0] LPIN_DLD = 6'h01;
  localparam logic [5:0] LPIN_HIGH = 6'h02;
  localparam logic [5:0] LPIN_CSRC = 6'h04;
  // Status pin control codes
  localparam logic [5:0] STAT_LOW = 6'h00;
  localparam logic [5:0] STAT_DLD = 6'h01;
  localparam logic [5:0] STAT_LDCMP = 6'h02;
  localparam logic [5:0] STAT_HOLD = 6'h03;
  // Reference monitor pin control codes
  localparam logic [4:0] RMON_LOW = 5'h00;
  localparam logic [4:0] RMON_DLD = 5'h01;
  localparam logic [4:0] RMON_LDCMP = 5'h02;
  // Output and channel counts
  localparam int unsigned NUM_OUT = 16;
  localparam int unsigned NUM_CH = 4;
  // Reset values
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [15:0] QCNT_RST = 16'h0000;
  typedef enum logic [1:0] {
    HO_RUN,
    HO_HOLD,
    HO_REARM
  } plh_ho_state_t;
endpackage
`default_nettype wire

// ==== design/plh_qual.sv ====
`default_nettype none
module plh_qual (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Lock flag and terminal count
  input wire logic lock_flag_i,
  input wire logic [15:0] term_cnt_i,
  // Qualified lock
  output logic charged_lock_qualifier_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic q;
  } plh_qual_st_t;

  plh_qual_st_t st_r;
  plh_qual_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (!lock_flag_i)
    begin
      // Any false cycle discharges at once
      st_nxt.cnt = plh_pkg::QCNT_RST;
      st_nxt.q = 1'b0;
    end
    else if (st_r.cnt >= term_cnt_i)
    begin
      st_nxt.q = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign charged_lock_qualifier_o = st_r.q;
endmodule
`default_nettype wire

// ==== tb/plh_pd_model.sv ====
`default_nettype none
module plh_pd_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Edge stream control
  input wire logic run_i,
  input wire logic [7:0] diff_i,
  // Phase detector side
  output logic first_edge_o,
  output logic second_edge_o,
  output logic [7:0] diff_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  // Four cycle spacing lets the bench stop between edges
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_r <= 2'h0;
      first_edge_o <= 1'b0;
      second_edge_o <= 1'b0;
      diff_o <= 8'h00;
    end
    else
    begin
      cnt_r <= (run_i || cnt_r != 2'h0) ? cnt_r + 2'h1 : 2'h0;
      first_edge_o <= run_i && cnt_r == 2'h0;
      // Unselected stream, must be ignored
      second_edge_o <= cnt_r == 2'h2;
      // Not valid off the edge, so never left stable
      diff_o <= (run_i && cnt_r == 2'h0) ? diff_i : ~diff_o;
    end
  end
endmodule
`default_nettype wire

// ==== tb/plh_lock_holdover_sva.sv ====
`default_nettype none
module plh_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Inputs
  input wire logic first_reference_edge_i,
  input wire logic second_reference_edge_i,
  input wire logic dld_disable_i,
  input wire logic [5:0] lock_pin_ctrl_i,
  input wire logic holdover_en_i,
  input wire logic ext_holdover_i,
  input wire logic sync_n_i,
  input wire logic [3:0] ignore_sync_i,
  // Outputs
  input wire logic edge_window_lock_flag_o,
  input wire logic charged_lock_qualifier_o,
  input wire logic lock_pin_o,
  input wire logic cp_hiz_o,
  input wire logic b_cnt_reset_o,
  input wire logic [3:0] dist_off_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_pulse;
    b_cnt_reset_o ##1 !b_cnt_reset_o;
  endsequence
  sequence s_unlocked2;
    !edge_window_lock_flag_o ##1 !edge_window_lock_flag_o;
  endsequence
  property p_gate;
    !holdover_en_i |=> !cp_hiz_o;
  endproperty
  property p_fall;
    holdover_en_i && ext_holdover_i && $fell(sync_n_i) |=> cp_hiz_o;
  endproperty
  property p_wait;
    cp_hiz_o && holdover_en_i && !first_reference_edge_i && !second_reference_edge_i
      |=> cp_hiz_o;
  endproperty
  property p_exit;
    $fell(cp_hiz_o) && $past(holdover_en_i) |-> s_pulse;
  endproperty
  property p_dld_off;
    dld_disable_i |=> !edge_window_lock_flag_o;
  endproperty
  property p_csrc;
    lock_pin_ctrl_i == plh_pkg::LPIN_CSRC |=> lock_pin_o == $past(charged_lock_qualifier_o);
  endproperty
  property p_dld_pin;
    lock_pin_ctrl_i == plh_pkg::LPIN_DLD |=> lock_pin_o == $past(edge_window_lock_flag_o);
  endproperty
  property p_dist;
    1'b1 |=> dist_off_o == $past(~ignore_sync_i & {4{~sync_n_i}});
  endproperty
  property p_qual;
    s_unlocked2 |-> !charged_lock_qualifier_o;
  endproperty
  a_gate: assert property (p_gate) else $error("hiz while disabled");
  a_fall: assert property (p_fall) else $error("no hiz on sync fall");
  a_wait: assert property (p_wait) else $error("hiz left without edge");
  a_exit: assert property (p_exit) else $error("no counter reset pulse");
  a_dld_off: assert property (p_dld_off) else $error("flag while disabled");
  a_csrc: assert property (p_csrc) else $error("pin not qualifier");
  a_dld_pin: assert property (p_dld_pin) else $error("pin not flag");
  a_dist: assert property (p_dist) else $error("channel off wrong");
  a_qual: assert property (p_qual) else $error("qualifier not cleared");
endmodule
bind plh_lock_holdover plh_chk plh_chk_i (.core_clk_i, .sys_rst_i,
  .first_reference_edge_i, .second_reference_edge_i, .dld_disable_i, .lock_pin_ctrl_i,
  .holdover_en_i, .ext_holdover_i, .sync_n_i, .ignore_sync_i, .edge_window_lock_flag_o,
  .charged_lock_qualifier_o, .lock_pin_o, .cp_hiz_o, .b_cnt_reset_o, .dist_off_o);
`default_nettype wire

// ==== tb/plh_lock_holdover_test.sv ====
`default_nettype none
module plh_lock_holdover_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, sys_rst_i, first_reference_edge_i, second_reference_edge_i, run;
  logic lock_window_sel_i, dld_disable_i, lock_cmp_en_i, holdover_en_i, ext_holdover_i;
  logic sync_n_i, auto_switch_en_i, prefer_second_i, edge_window_lock_flag_o;
  logic charged_lock_qualifier_o, lock_pin_o, status_pin_o, reference_monitor_pin_o;
  logic cp_hiz_o, b_cnt_reset_o, ref_sel_o;
  logic [7:0] edge_diff_i, diff;
  logic [1:0] lock_count_sel_i, backlash_width_i, ref_buf_en_i;
  logic [15:0] qual_term_cnt_i, out_req_en_i, out_gate_en_i, out_en_o;
  logic [5:0] lock_pin_ctrl_i, status_pin_ctrl_i;
  logic [4:0] monitor_pin_ctrl_i;
  logic [3:0] ignore_sync_i, dist_off_o;
  int error_cnt, total_checks, bcnt;
  plh_pd_model plh_pd_model_i (.core_clk_i, .sys_rst_i, .run_i(run), .diff_i(diff),
    .first_edge_o(first_reference_edge_i), .second_edge_o(second_reference_edge_i),
    .diff_o(edge_diff_i));
  plh_lock_holdover plh_lock_holdover_i (.core_clk_i, .sys_rst_i, .first_reference_edge_i,
    .second_reference_edge_i, .edge_diff_i, .lock_count_sel_i, .lock_window_sel_i,
    .backlash_width_i, .dld_disable_i, .qual_term_cnt_i, .lock_pin_ctrl_i,
    .status_pin_ctrl_i, .monitor_pin_ctrl_i, .lock_cmp_en_i, .holdover_en_i,
    .ext_holdover_i, .sync_n_i, .auto_switch_en_i, .prefer_second_i, .ref_buf_en_i,
    .ignore_sync_i, .out_req_en_i, .out_gate_en_i, .edge_window_lock_flag_o,
    .charged_lock_qualifier_o, .lock_pin_o, .status_pin_o, .reference_monitor_pin_o,
    .cp_hiz_o, .b_cnt_reset_o, .ref_sel_o, .dist_off_o, .out_en_o);
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
    if (b_cnt_reset_o === 1'b1)
      bcnt++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Run n selected edges, then let the flag settle
  task automatic edges(input int n, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    diff <= d;
    run <= 1'b1;
    while (k < n)
    begin
      @(posedge core_clk_i);
      if (first_reference_edge_i === 1'b1)
        k++;
    end
    run <= 1'b0;
    cyc(2);
  endtask
  task automatic lock_try(input logic [1:0] s, input logic w, input logic [1:0] b,
    input logic [7:0] d, input int n, input logic e);
    edges(1, 8'hff);
    lock_count_sel_i <= s;
    lock_window_sel_i <= w;
    backlash_width_i <= b;
    edges(n, d);
    chk(edge_window_lock_flag_o, e);
  endtask
  task automatic t_lock;
    cyc(2);
    chk(ref_sel_o, 1'b0);
    lock_try(2'h0, 1'b0, 2'h0, 8'h18, 4, 1'b0);
    lock_try(2'h0, 1'b0, 2'h0, 8'h18, 5, 1'b1);
    lock_try(2'h0, 1'b1, 2'h0, 8'h18, 5, 1'b0);
    lock_try(2'h0, 1'b1, 2'h1, 8'h0b, 5, 1'b1);
    lock_try(2'h1, 1'b0, 2'h0, 8'h10, 15, 1'b0);
    lock_try(2'h1, 1'b0, 2'h0, 8'h10, 16, 1'b1);
    edges(3, 8'h2f);
    chk(edge_window_lock_flag_o, 1'b1);
    edges(1, 8'h31);
    chk(edge_window_lock_flag_o, 1'b0);
    dld_disable_i <= 1'b1;
    edges(16, 8'h10);
    chk(edge_window_lock_flag_o, 1'b0);
    dld_disable_i <= 1'b0;
  endtask
  // Preferred second reference, then swapped back by switchover
  task automatic t_ref;
    prefer_second_i <= 1'b1;
    cyc(3);
    chk(ref_sel_o, 1'b1);
    auto_switch_en_i <= 1'b1;
    cyc(3);
    chk(ref_sel_o, 1'b0);
    prefer_second_i <= 1'b0;
    auto_switch_en_i <= 1'b0;
    cyc(2);
  endtask
  task automatic t_man;
    int b;
    ext_holdover_i <= 1'b1;
    sync_n_i <= 1'b0;
    cyc(3);
    chk(cp_hiz_o, 1'b0);
    chk(dist_off_o, 4'ha);
    holdover_en_i <= 1'b1;
    cyc(3);
    chk(cp_hiz_o, 1'b0);
    sync_n_i <= 1'b1;
    cyc(2);
    sync_n_i <= 1'b0;
    cyc(3);
    chk(cp_hiz_o, 1'b1);
    b = bcnt;
    sync_n_i <= 1'b1;
    cyc(20);
    chk(cp_hiz_o, 1'b1);
    edges(1, 8'h18);
    chk(cp_hiz_o, 1'b0);
    chk(16'(bcnt - b), 16'h0001);
    holdover_en_i <= 1'b0;
    ext_holdover_i <= 1'b0;
  endtask
  task automatic t_auto;
    int b;
    lock_cmp_en_i <= 1'b1;
    lock_pin_ctrl_i <= plh_pkg::LPIN_CSRC;
    lock_try(2'h0, 1'b0, 2'h0, 8'h18, 5, 1'b1);
    chk(charged_lock_qualifier_o, 1'b0);
    chk(out_en_o, 16'hff00);
    cyc(12);
    chk(charged_lock_qualifier_o, 1'b1);
    chk(out_en_o, 16'hffff);
    chk(lock_pin_o, 1'b1);
    chk(status_pin_o, 1'b1);
    chk(reference_monitor_pin_o, 1'b1);
    monitor_pin_ctrl_i <= plh_pkg::RMON_LDCMP;
    cyc(3);
    chk(reference_monitor_pin_o, 1'b1);
    holdover_en_i <= 1'b1;
    sync_n_i <= 1'b0;
    cyc(3);
    chk(cp_hiz_o, 1'b0);
    sync_n_i <= 1'b1;
    edges(1, 8'hff);
    cyc(3);
    chk(cp_hiz_o, 1'b1);
    status_pin_ctrl_i <= plh_pkg::STAT_HOLD;
    cyc(3);
    chk(status_pin_o, 1'b1);
    chk(reference_monitor_pin_o, 1'b0);
    cyc(10);
    chk(cp_hiz_o, 1'b1);
    b = bcnt;
    edges(1, 8'hff);
    chk(cp_hiz_o, 1'b0);
    chk(16'(bcnt - b), 16'h0001);
    cyc(10);
    chk(cp_hiz_o, 1'b0);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    error_cnt++;
    final_report;
  end
  initial
  begin
    sys_rst_i = 1'b1;
    sync_n_i = 1'b1;
    diff = 8'h00;
    {run, lock_window_sel_i, dld_disable_i, lock_cmp_en_i} = 4'h0;
    {holdover_en_i, ext_holdover_i, auto_switch_en_i, prefer_second_i} = 4'h0;
    {lock_count_sel_i, backlash_width_i} = 4'h0;
    ref_buf_en_i = 2'h1;
    qual_term_cnt_i = 16'h0008;
    out_req_en_i = 16'hffff;
    out_gate_en_i = 16'h00ff;
    lock_pin_ctrl_i = plh_pkg::LPIN_DLD;
    status_pin_ctrl_i = plh_pkg::STAT_LDCMP;
    monitor_pin_ctrl_i = plh_pkg::RMON_DLD;
    ignore_sync_i = 4'h5;
    cyc(10);
    sys_rst_i <= 1'b0;
    t_lock;
    t_ref;
    t_man;
    t_auto;
    final_report;
  end
endmodule
`default_nettype wire
